// ### tb/ccsb_core_asserts.sv
/* port assertions for the execution slice.
   assumes one clock and the async active-low reset. */
`timescale 1ns/1ps
module ccsb_core_asserts (
  input logic core_clk_in,
  input logic resetn_in,
  input logic op_valid_in,
  input ccsb_pkg::ccsb_op_t op_code_in,
  input logic [6:0] file_addr_in,
  input logic dest_sel_in,
  input logic [7:0] literal_in,
  input logic [10:0] jump_target_in,
  input logic [7:0] file_rdata_in,
  input logic [6:0] upper_address_latch_in,
  input logic op_ready_out,
  input logic file_we_out,
  input logic [6:0] file_waddr_out,
  input logic [7:0] file_wdata_out,
  input logic [7:0] accumulator_out,
  input logic null_result_flag_out,
  input logic skip_out,
  input logic pc_load_out,
  input logic [14:0] pc_value_out
);
  import ccsb_pkg::*;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  logic tk;
  logic [3:0] ulh;
  // an op counts only when offered in a ready slot
  assign tk = op_valid_in && op_ready_out;
  assign ulh = upper_address_latch_in[6:3];
  a_clear_file: assert property (tk && op_code_in == clear_file_op |=> file_we_out &&
    file_wdata_out == 8'h00 && file_waddr_out == $past(file_addr_in) &&
    null_result_flag_out) else $error("clear file");
  a_clear_acc: assert property (tk && op_code_in == clear_acc_op |=>
    accumulator_out == 8'h00 && null_result_flag_out) else $error("clear acc");
  a_dec_dest: assert property (tk && op_code_in == decrement_file_op |=>
    file_we_out == $past(dest_sel_in) && null_result_flag_out == ($past(file_rdata_in) == 8'h01)) else $error("dec");
  a_or_literal: assert property (tk && op_code_in == or_literal_op |=>
    accumulator_out == ($past(accumulator_out) | $past(literal_in)) &&
    null_result_flag_out == (accumulator_out == 8'h00)) else $error("or literal");
  a_skip_flags: assert property (tk &&
    (op_code_in == decrement_skip_op || op_code_in == increment_skip_op) |=>
    $stable(null_result_flag_out)) else $error("skip flag");
  a_inc_skip: assert property (tk && op_code_in == increment_skip_op |=>
    skip_out == ($past(file_rdata_in) == 8'hFF)) else $error("inc skip");
  a_slot_lost: assert property (skip_out || pc_load_out |->
    !op_ready_out ##1 op_ready_out && !skip_out && !pc_load_out) else $error("slot");
  a_jump_pc: assert property (tk && op_code_in == jump_absolute_op |=> pc_load_out &&
    pc_value_out == {$past(ulh), $past(jump_target_in)}) else $error("jump");
  // an op offered in the discarded slot must raise no write, skip or pc-load strobe and leave acc and flag unchanged
  a_refused_quiet: assert property (!op_ready_out |=> !file_we_out && !skip_out && !pc_load_out &&
    $stable(accumulator_out) && $stable(null_result_flag_out)) else $error("refused slot");
  c_skip: cover property (skip_out);
  c_jump: cover property (pc_load_out);
  c_refused: cover property (op_valid_in && !op_ready_out);
endmodule : ccsb_core_asserts
bind ccsb_core ccsb_core_asserts u_asserts (.*);

// ### tb/ccsb_regfile_model.sv
/* register file stand-in beside the slice.
   assumes writes land on the edge after the write strobe. */
`timescale 1ns/1ps
module ccsb_regfile_model (
  input logic clk_in,
  input logic we_in,
  input logic [6:0] waddr_in,
  input logic [7:0] wdata_in,
  input logic [6:0] raddr_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [128] = '{default: 8'h00};
  // same-cycle read, the slice samples it with the op
  assign rdata_out = mem[raddr_in];
  // strobe lasts one cycle, so one write per op
  always @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end
endmodule : ccsb_regfile_model

// ### tb/test_clear_count_skip_branch_ops.sv
/* bench for the clear/count/skip/branch slice.
   assumes the register file stand-in; results read one cycle after the op. */
`timescale 1ns/1ps
module test_clear_count_skip_branch_ops;
  import ccsb_pkg::*;
  logic clk = 1'h0, resetn = 1'h0, v = 1'h0, ds = 1'h0, rdy, we, fl, sk, pl;
  ccsb_op_t oc = nop_op;
  logic [6:0] fa = 7'h00, ul = 7'h00, wa;
  logic [7:0] lit = 8'h00, rd, wd, acc;
  logic [10:0] jt = 11'h000;
  logic [14:0] pv;
  int fail_count = 0, check_count = 0;
  // status word: ready and strobes, flag, acc, write addr, write data
  wire logic [31:0] ob = {rdy, we, sk, pl, 3'h0, fl, acc, 1'h0, wa, wd};
  // 5 ns period
  always #2.5 clk = ~clk;
  ccsb_core dut (.core_clk_in(clk), .resetn_in(resetn), .op_valid_in(v), .op_code_in(oc), .file_addr_in(fa),
    .dest_sel_in(ds), .literal_in(lit), .jump_target_in(jt), .file_rdata_in(rd), .upper_address_latch_in(ul),
    .op_ready_out(rdy), .file_we_out(we), .file_waddr_out(wa), .file_wdata_out(wd), .accumulator_out(acc),
    .null_result_flag_out(fl), .skip_out(sk), .pc_load_out(pl), .pc_value_out(pv));
  ccsb_regfile_model rf (.clk_in(clk), .we_in(we), .waddr_in(wa), .wdata_in(wd), .raddr_in(fa), .rdata_out(rd));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // h keeps valid up into the next slot, to offer an op there
  task automatic step(input ccsb_op_t c, input logic [6:0] a, input logic s, input logic [10:0] k,
      input logic h, input logic [31:0] e);
    @(posedge clk);
    oc <= c;
    {fa, ds, lit, jt, v} <= {a, s, k[7:0], k, 1'h1};
    @(posedge clk);
    v <= h;
    @(negedge clk);
    chk("status", e, ob);
  endtask : step
  // one slot with valid dropped
  task automatic gap(input logic [31:0] e);
    @(posedge clk);
    v <= 1'h0;
    @(negedge clk);
    chk("status", e, ob);
  endtask : gap
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // cut a hang short
  initial begin
    repeat (500) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  // reset for three cycles, then walk the op set
  initial begin
    rf.mem[3] = 8'h05;
    rf.mem[5] = 8'h01;
    rf.mem[6] = 8'hFF;
    rf.mem[7] = 8'h10;
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    ul <= 7'h78;
    @(negedge clk);
    chk("reset", 32'h80000000, ob);
    step(or_literal_op, 7'h00, 1'h0, 11'h05A, 1'h0, 32'h805A0000);
    step(clear_acc_op, 7'h00, 1'h0, 11'h000, 1'h0, 32'h81000000);
    step(decrement_file_op, 7'h00, 1'h0, 11'h000, 1'h0, 32'h80FF0000);
    step(clear_file_op, 7'h7F, 1'h0, 11'h000, 1'h0, 32'hC1FF7F00);
    step(decrement_file_op, 7'h03, 1'h1, 11'h000, 1'h0, 32'hC0FF0304);
    $display("test arith done");
    step(decrement_skip_op, 7'h05, 1'h1, 11'h000, 1'h1, 32'h60FF0500);
    gap(32'h80FF0500);
    step(increment_skip_op, 7'h06, 1'h0, 11'h000, 1'h0, 32'h20000500);
    gap(32'h80000500);
    step(increment_skip_op, 7'h07, 1'h0, 11'h000, 1'h0, 32'h80110500);
    $display("test skip done");
    step(jump_absolute_op, 7'h00, 1'h0, 11'h123, 1'h0, 32'h10110500);
    chk("pc", 32'h00007923, {17'h00000, pv});
    gap(32'h80110500);
    $display("test jump done");
    // non-zero skip result costs no slot; nop touches nothing
    step(decrement_skip_op, 7'h03, 1'h0, 11'h000, 1'h0, 32'h80030500);
    step(nop_op, 7'h03, 1'h1, 11'h0FF, 1'h0, 32'h80030500);
    chk("pc hold", 32'h00007923, {17'h00000, pv});
    $display("test order done");
    // reset again in mid-run, all ports back to their reset values
    @(posedge clk);
    resetn <= 1'h0;
    @(posedge clk);
    resetn <= 1'h1;
    @(negedge clk);
    chk("reset again", 32'h80000000, ob);
    chk("pc reset", 32'h00000000, {17'h00000, pv});
    $display("test reset done");
    end_of_test();
  end
endmodule : test_clear_count_skip_branch_ops

// ### verilog/ccsb_alu.sv
/*
  Combinational result unit: computes value, destination, flag update and
  skip/branch decisions for one decoded operation.
  Assumes operands are stable for the whole cycle.
*/
`timescale 1ns/1ps
module ccsb_alu (
  ccsb_alu_if.alu bus
);
  import ccsb_pkg::*;

  // 8-bit arithmetic wraps modulo 256 by width
  assign bus.zero = (bus.result == ZERO_BYTE);

  // per-operation result and routing
  always_comb begin
    bus.result = ZERO_BYTE;
    bus.wr_acc = 1'b0;
    bus.wr_file = 1'b0;
    bus.upd_flag = 1'b0;
    bus.skip = 1'b0;
    bus.jump = 1'b0;
    case (bus.op)
      clear_file_op: begin
        bus.result = ZERO_BYTE;
        bus.wr_file = 1'b1;
        bus.upd_flag = 1'b1;
      end
      clear_acc_op: begin
        bus.result = ZERO_BYTE;
        bus.wr_acc = 1'b1;
        bus.upd_flag = 1'b1;
      end
      decrement_file_op: begin
        bus.result = bus.file_val - ONE_BYTE;
        bus.wr_acc = (bus.dest_sel == DEST_ACC);
        bus.wr_file = (bus.dest_sel == DEST_FILE);
        bus.upd_flag = 1'b1;
      end
      decrement_skip_op: begin
        bus.result = bus.file_val - ONE_BYTE;
        bus.wr_acc = (bus.dest_sel == DEST_ACC);
        bus.wr_file = (bus.dest_sel == DEST_FILE);
        bus.skip = (bus.result == ZERO_BYTE);
      end
      increment_skip_op: begin
        bus.result = bus.file_val + ONE_BYTE;
        bus.wr_acc = (bus.dest_sel == DEST_ACC);
        bus.wr_file = (bus.dest_sel == DEST_FILE);
        bus.skip = (bus.result == ZERO_BYTE);
      end
      jump_absolute_op: begin
        bus.jump = 1'b1;
      end
      or_literal_op: begin
        bus.result = bus.acc_val | bus.literal;
        bus.wr_acc = 1'b1;
        bus.upd_flag = 1'b1;
      end
      default: begin
        bus.result = ZERO_BYTE;
      end
    endcase
  end
endmodule : ccsb_alu

// ### verilog/ccsb_alu_if.sv
/*
  Carrier between the execution top and its combinational result unit.
  Assumes both ends sit on the same clock; no storage inside.
*/
`timescale 1ns/1ps
interface ccsb_alu_if;
  import ccsb_pkg::*;
  ccsb_op_t op;
  logic dest_sel;
  logic [DATA_W-1:0] file_val;
  logic [DATA_W-1:0] acc_val;
  logic [DATA_W-1:0] literal;
  logic [DATA_W-1:0] result;
  logic wr_acc;
  logic wr_file;
  logic upd_flag;
  logic zero;
  logic skip;
  logic jump;

  modport ctrl (output op, dest_sel, file_val, acc_val, literal,
                input result, wr_acc, wr_file, upd_flag, zero, skip, jump);
  modport alu (input op, dest_sel, file_val, acc_val, literal,
               output result, wr_acc, wr_file, upd_flag, zero, skip, jump);
endinterface : ccsb_alu_if

// ### verilog/ccsb_core.sv
/*
  Execution slice for clear, decrement, skip-on-zero counts, absolute jump and
  OR-literal. Holds the accumulator and null-result flag; drives file writes and
  program counter loads.
  Assumes the decoder and register file share core_clk_in, file_rdata_in is the
  addressed register's current value, and fetch honours skip/jump pulses.
*/
// Operation
// - Clearing a file register writes zero to the addressed register 0..127 and sets the null flag.
// - Destination select 0 sends the result to the accumulator, 1 writes it back to the file register.
// - Decrement-file subtracts one, stores at the chosen destination and updates the null flag.
// - Clearing the accumulator loads zero into it and sets the null flag.
// - Decrement-and-skip stores the result and on zero discards the next instruction, flags untouched.
// - Increment-and-skip stores the result and on zero the next instruction becomes a no-op, flags untouched.
// - The absolute jump loads its 11-bit operand into the low eleven program counter bits.
// - The jump fills program counter bits 14..11 from upper address latch bits 6..3.
// - The jump takes two instruction cycles and leaves the flags alone.
// - OR-literal ORs the accumulator with an 8-bit literal, stores it there and updates the null flag.
`timescale 1ns/1ps
module ccsb_core (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic op_valid_in,
  input wire ccsb_pkg::ccsb_op_t op_code_in,
  input wire logic [ccsb_pkg::FADDR_W-1:0] file_addr_in,
  input wire logic dest_sel_in,
  input wire logic [ccsb_pkg::DATA_W-1:0] literal_in,
  input wire logic [ccsb_pkg::JUMP_W-1:0] jump_target_in,
  input wire logic [ccsb_pkg::DATA_W-1:0] file_rdata_in,
  input wire logic [ccsb_pkg::LATCH_W-1:0] upper_address_latch_in,
  output logic op_ready_out,
  output logic file_we_out,
  output logic [ccsb_pkg::FADDR_W-1:0] file_waddr_out,
  output logic [ccsb_pkg::DATA_W-1:0] file_wdata_out,
  output logic [ccsb_pkg::DATA_W-1:0] accumulator_out,
  output logic null_result_flag_out,
  output logic skip_out,
  output logic pc_load_out,
  output logic [ccsb_pkg::PC_W-1:0] pc_value_out
);
  import ccsb_pkg::*;

  ccsb_alu_if alu_bus ();
  ccsb_state_t state;
  logic take;

  // an operation is taken only outside the discarded slot
  assign take = op_valid_in && (state == ccsb_st_run);

  // operands to the result unit
  assign alu_bus.op = take ? op_code_in : nop_op;
  assign alu_bus.dest_sel = dest_sel_in;
  assign alu_bus.file_val = file_rdata_in;
  assign alu_bus.acc_val = accumulator_out;
  assign alu_bus.literal = literal_in;

  ccsb_alu u_alu (
    .bus(alu_bus)
  );

  // slot sequencing: skip or jump burns the following cycle as a no-op
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ccsb_st_run;
      op_ready_out <= 1'b1;
    end else begin
      case (state)
        ccsb_st_run: begin
          if (alu_bus.skip || alu_bus.jump) begin
            state <= ccsb_st_flush;
            op_ready_out <= 1'b0;
          end else begin
            state <= ccsb_st_run;
            op_ready_out <= 1'b1;
          end
        end
        ccsb_st_flush: begin
          state <= ccsb_st_run;
          op_ready_out <= 1'b1;
        end
        default: begin
          state <= ccsb_st_run;
          op_ready_out <= 1'b1;
        end
      endcase
    end
  end

  // accumulator write-back
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      accumulator_out <= ACC_RST;
    end else if (alu_bus.wr_acc) begin
      accumulator_out <= alu_bus.result;
    end
  end

  // null-result flag; skips and jumps never touch it
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      null_result_flag_out <= FLAG_RST;
    end else if (alu_bus.upd_flag) begin
      null_result_flag_out <= alu_bus.zero;
    end
  end

  // file register write port, one-cycle strobe
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      file_we_out <= 1'b0;
      file_waddr_out <= FADDR_RST;
      file_wdata_out <= ZERO_BYTE;
    end else begin
      file_we_out <= alu_bus.wr_file;
      if (alu_bus.wr_file) begin
        file_waddr_out <= file_addr_in;
        file_wdata_out <= alu_bus.result;
      end
    end
  end

  // skip pulse tells fetch to discard the instruction already in flight
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      skip_out <= 1'b0;
    end else begin
      skip_out <= alu_bus.skip;
    end
  end

  // program counter load; upper bits come from the latch, not the operand
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc_load_out <= 1'b0;
      pc_value_out <= PC_RST;
    end else begin
      pc_load_out <= alu_bus.jump;
      if (alu_bus.jump) begin
        pc_value_out <= {upper_address_latch_in[LATCH_HI:LATCH_LO], jump_target_in};
      end
    end
  end
endmodule : ccsb_core

// ### verilog/ccsb_pkg.sv
/*
  Shared constants and types for the clear/count/skip/branch execution slice.
  Assumes one instruction clock; decoder presents one decoded operation per cycle.
*/
package ccsb_pkg;
  // datapath and address widths
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int JUMP_W = 11;
  localparam int PC_W = 15;
  localparam int LATCH_W = 7;
  // latch field copied into the upper program counter bits
  localparam int LATCH_HI = 6;
  localparam int LATCH_LO = 3;
  // destination select encoding
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  // reset values and constants
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  // skips and jumps occupy this many instruction cycles
  localparam int SKIP_CYCLES = 2;

  typedef enum logic [2:0] {
    nop_op,
    clear_file_op,
    clear_acc_op,
    decrement_file_op,
    decrement_skip_op,
    increment_skip_op,
    jump_absolute_op,
    or_literal_op
  } ccsb_op_t;

  typedef enum logic {
    ccsb_st_run,
    ccsb_st_flush
  } ccsb_state_t;
endpackage : ccsb_pkg
